// ===== common/dtc_pkg.sv
package dtc_pkg;

  // Mode register field positions used by the termination logic.
  localparam int MR1_NOM_B9  = 9;
  localparam int MR1_NOM_B6  = 6;
  localparam int MR1_NOM_B2  = 2;
  localparam int MR2_WR_B10  = 10;
  localparam int MR2_WR_B9   = 9;
  localparam int MR0_DLL_B12 = 12;

  // Termination latency offsets in clock cycles.
  localparam int LAT_OFFSET      = 2;
  localparam int CHOP_EXTRA      = 4;
  localparam int FULL_EXTRA      = 6;
  localparam int MIN_PIN_HIGH_SHORT = 4;
  localparam int MIN_PIN_HIGH_LONG  = 6;
  localparam int ASYNC_MIN_DELAY = 2;

  // Widths.
  localparam int LAT_W   = 5;
  localparam int NOM_W   = 3;
  localparam int WRS_W   = 2;
  localparam int MODE_W  = 16;
  localparam int DLY_MAX = 32;

  // Register map, byte addresses on the bus.
  localparam logic [3:0] ADR_CTRL   = 4'h0;
  localparam logic [3:0] ADR_MR0    = 4'h4;
  localparam logic [3:0] ADR_MR1    = 4'h8;
  localparam logic [3:0] ADR_MR2    = 4'hC;

  // Control register bits.
  localparam int CTRL_CWL_LSB  = 0;
  localparam int CTRL_AL_LSB   = 8;
  localparam int CTRL_SREF_BIT = 16;
  localparam int CTRL_PPD_BIT  = 17;
  localparam int CTRL_DLLON_BIT = 18;
  localparam int STAT_TERM_BIT = 24;
  localparam int STAT_WRS_BIT  = 25;
  localparam int STAT_ASYNC_BIT = 26;

  localparam logic [4:0]  CWL_RESET = 5'h05;
  localparam logic [31:0] CTRL_RESET = 32'h0004_0005;

  // Termination strength selection.
  typedef enum logic [1:0] {
    DTC_OFF,
    DTC_NOMINAL,
    DTC_WRITE
  } dtc_strength_t;

endpackage : dtc_pkg

// ===== rtl/dtc_delay_line.sv
`timescale 1ns/100ps
// Variable-tap shift line: a bit entered now appears tap cycles later.
module dtc_delay_line
  import dtc_pkg::*;
#(
  parameter int DEPTH = DLY_MAX
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic             d_i,
  input  wire logic [LAT_W-1:0] tap_i,
  output logic                  q_o
);

  logic [DEPTH-1:0] line_reg;

  // The line shifts every enabled cycle; the tap picks the latency.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      line_reg <= '0;
    end
    else if (ce_i)
    begin
      line_reg <= {line_reg[DEPTH-2:0], d_i};
    end
  end

  // A tap of zero passes the input straight through.
  always_comb
  begin
    if (tap_i == '0)
    begin
      q_o = d_i;
    end
    else
    begin
      q_o = line_reg[tap_i - 5'd1];
    end
  end

endmodule : dtc_delay_line

// ===== rtl/dtc_term_ctrl.sv
`timescale 1ns/100ps
// Operation
// R1 - Dynamic termination is on when mode register two bit 9 or 10 is set.
// R2 - Nominal strength comes from mode register one bits 9, 6 and 2.
// R3 - Write strength comes from mode register two bits 10 and 9.
// R4 - Without writes, nominal strength applies; pin switches it with on/off latency.
// R5 - Every write variant triggers a strength change when dynamic termination is on.
// R6 - Write strength is selected write latency minus two after the write.
// R7 - Nominal returns off latency plus 4 (chop) or plus 6 (full) after write.
// R8 - Return latency follows burst length, fixed or chosen on the fly.
// R9 - Pin still switches termination on and off during writes.
// R10 - Turn-on and turn-off latency both equal write latency minus two.
// R11 - Controller clears write-strength bits before running with the DLL off.
// R12 - Controller keeps the pin high at least 4 cycles after raising it.
// R13 - After a write with pin high, pin stays high 4 or 6 cycles.
// R14 - Pin-high minimums count from pin high or write to pin low.
// R15 - Asynchronous mode when DLL frozen in precharge power-down per mode register zero.
// R16 - Asynchronous mode applies no additive latency to the pin.
// R17 - Asynchronous on/off delays count from pin sampled, each at least 2.
// R18 - Pin receiver stays active in power-down; controller issues no reads or writes.
// R19 - Synchronous mode latencies equal write latency plus additive latency minus two.
// R20 - Synchronous mode applies whenever the DLL is on and locked.
// R21 - Self-refresh turns termination off and ignores the pin.
// R22 - With dynamic termination off, writes keep the nominal strength.
module dtc_term_ctrl
  import dtc_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        CE_I,
  input  wire logic        TERM_PIN_I,
  input  wire logic        WRITE_CMD_I,
  input  wire logic        WRITE_CHOP_I,
  input  wire logic        PIN_HIGH_VIOL_CLR_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [3:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic [31:0]      DAT_O,
  output logic             ACK_O,
  output logic             ERR_O,
  output logic             TERM_EN_O,
  output logic             TERM_WRITE_SEL_O,
  output logic [NOM_W-1:0] NOM_STRENGTH_O,
  output logic [WRS_W-1:0] WR_STRENGTH_O,
  output logic             ASYNC_MODE_O
);

  logic             rst_sync1_reg;
  logic             rst_sync2_reg;
  logic             rst_n;
  logic             pin_sync1_reg;
  logic             pin_reg;
  logic [31:0]      ctrl_reg;
  logic [MODE_W-1:0] mr0_reg;
  logic [MODE_W-1:0] mr1_reg;
  logic [MODE_W-1:0] mr2_reg;
  logic             ack_reg;
  logic [31:0]      dat_reg;
  logic             dyn_en;
  logic             async_mode;
  logic             self_refresh;
  logic [LAT_W-1:0] cwl;
  logic [LAT_W-1:0] al;
  logic [LAT_W-1:0] term_lat;
  logic [LAT_W-1:0] cnw_lat;
  logic             pin_delayed;
  logic             write_start;
  logic [LAT_W-1:0] wr_end_cnt_reg;
  logic [LAT_W-1:0] wr_end_next;
  logic             wr_active_reg;
  logic             term_en_reg;
  logic             wr_sel_reg;
  logic [2:0]       async_cnt_reg;
  logic             async_term_reg;
  logic [2:0]       high_cnt_reg;
  logic             viol_reg;
  logic             bus_req;
  logic             bus_ok;

  // Byte lanes select which bytes of a register a write replaces.
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // Address decode shared by read and write paths.
  function automatic logic adr_valid(input logic [3:0] adr);
    return (adr == ADR_CTRL) || (adr == ADR_MR0) || (adr == ADR_MR1) || (adr == ADR_MR2);
  endfunction : adr_valid

  // Reset release goes through two flops so it is clean against CLK_I.
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rst_n = rst_sync2_reg;

  // The pin comes from outside; the receiver stays alive in power-down.
  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_sync1_reg <= 1'b0;
      pin_reg       <= 1'b0;
    end
    else if (CE_I)
    begin
      pin_sync1_reg <= TERM_PIN_I; // R18
      pin_reg       <= pin_sync1_reg;
    end
  end

  // Mode fields and derived latencies.
  assign cwl          = ctrl_reg[CTRL_CWL_LSB +: LAT_W];
  assign al           = ctrl_reg[CTRL_AL_LSB +: LAT_W];
  assign self_refresh = ctrl_reg[CTRL_SREF_BIT];
  assign dyn_en       = mr2_reg[MR2_WR_B9] | mr2_reg[MR2_WR_B10]; // R1
  assign NOM_STRENGTH_O = {mr1_reg[MR1_NOM_B9], mr1_reg[MR1_NOM_B6], mr1_reg[MR1_NOM_B2]}; // R2
  assign WR_STRENGTH_O  = {mr2_reg[MR2_WR_B10], mr2_reg[MR2_WR_B9]}; // R3
  // Frozen DLL in precharge power-down selects the asynchronous path.
  assign async_mode = ctrl_reg[CTRL_PPD_BIT] & ~mr0_reg[MR0_DLL_B12]; // R15 R20
  // Latencies saturate at zero so a tiny write latency does not wrap.
  assign term_lat = (cwl + al > 5'(LAT_OFFSET)) ? 5'(cwl + al - 5'(LAT_OFFSET)) : '0; // R10 R19
  assign cnw_lat  = term_lat; // R6

  // The pin is delayed by the full synchronous latency.
  dtc_delay_line #(
    .DEPTH (DLY_MAX)
  ) u_pin_delay (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n),
    .ce_i    (CE_I),
    .d_i     (pin_reg),
    .tap_i   (term_lat),
    .q_o     (pin_delayed)
  );

  // Synchronous on/off follows the delayed pin; writes never gate it.
  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      term_en_reg <= 1'b0;
    end
    else if (CE_I)
    begin
      if (self_refresh)
      begin
        term_en_reg <= 1'b0; // R21
      end
      else if (async_mode)
      begin
        term_en_reg <= async_term_reg; // R16
      end
      else
      begin
        term_en_reg <= pin_delayed; // R4 R9
      end
    end
  end

  // Asynchronous path: pin level must hold two cycles before it takes effect.
  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      async_cnt_reg  <= '0;
      async_term_reg <= 1'b0;
    end
    else if (CE_I)
    begin
      if (pin_reg == async_term_reg)
      begin
        async_cnt_reg <= '0;
      end
      else if (async_cnt_reg >= 3'(ASYNC_MIN_DELAY - 1))
      begin
        async_term_reg <= pin_reg; // R17
        async_cnt_reg  <= '0;
      end
      else
      begin
        async_cnt_reg <= async_cnt_reg + 3'd1;
      end
    end
  end

  // A write only counts in synchronous, non-refresh operation.
  assign write_start = WRITE_CMD_I & dyn_en & ~async_mode & ~self_refresh; // R5 R22

  // Write strength window: starts after cnw, ends after off latency plus 4 or 6.
  assign wr_end_next = WRITE_CHOP_I ? 5'(term_lat + 5'(CHOP_EXTRA))
                                    : 5'(term_lat + 5'(FULL_EXTRA)); // R7 R8

  // Counter holds the cycles left in the write window; a new write reloads it.
  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_active_reg  <= 1'b0;
      wr_end_cnt_reg <= '0;
    end
    else if (CE_I)
    begin
      if (write_start)
      begin
        wr_active_reg  <= 1'b1;
        wr_end_cnt_reg <= wr_end_next;
      end
      else if (wr_active_reg)
      begin
        wr_end_cnt_reg <= wr_end_cnt_reg - 5'd1;
        if (wr_end_cnt_reg == 5'd1)
        begin
          wr_active_reg <= 1'b0;
        end
      end
    end
  end

  // Strength flips once the elapsed count reaches the cnw point.
  logic [LAT_W-1:0] wr_elapsed_reg;
  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_elapsed_reg <= '0;
      wr_sel_reg     <= 1'b0;
    end
    else if (CE_I)
    begin
      if (write_start)
      begin
        wr_elapsed_reg <= 5'd1;
        wr_sel_reg     <= (cnw_lat == '0); // R6
      end
      else if (wr_active_reg)
      begin
        wr_elapsed_reg <= wr_elapsed_reg + 5'd1;
        if (wr_end_cnt_reg == 5'd1)
        begin
          wr_sel_reg <= 1'b0; // R7
        end
        else if (wr_elapsed_reg == cnw_lat)
        begin
          wr_sel_reg <= 1'b1; // R6
        end
      end
      else
      begin
        wr_sel_reg <= 1'b0; // R22
      end
    end
  end

  // Watch the pin-high minimums; a violation is sticky until cleared.
  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      high_cnt_reg <= '0;
      viol_reg     <= 1'b0;
    end
    else if (CE_I)
    begin
      if (pin_reg && WRITE_CMD_I)
      begin
        high_cnt_reg <= WRITE_CHOP_I ? 3'(MIN_PIN_HIGH_SHORT - 1)
                                     : 3'(MIN_PIN_HIGH_LONG - 1); // R13 R14
      end
      else if (pin_reg && !pin_sync1_reg && high_cnt_reg > 3'd1)
      begin
        viol_reg <= 1'b1; // R12 R14
      end
      else if (pin_reg && high_cnt_reg != '0)
      begin
        high_cnt_reg <= high_cnt_reg - 3'd1;
      end
      else if (!pin_reg && pin_sync1_reg)
      begin
        high_cnt_reg <= 3'(MIN_PIN_HIGH_SHORT); // R12
      end
      if (PIN_HIGH_VIOL_CLR_I && !(pin_reg && !pin_sync1_reg && high_cnt_reg > 3'd1))
      begin
        viol_reg <= 1'b0;
      end
    end
  end

  // Wishbone slave: one wait state, unmapped addresses answer with err.
  assign bus_req = CYC_I & STB_I & ~ack_reg & ~ERR_O;
  assign bus_ok  = adr_valid(ADR_I);

  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_reg <= 1'b0;
      ERR_O   <= 1'b0;
    end
    else if (CE_I)
    begin
      ack_reg <= bus_req & bus_ok;
      ERR_O   <= bus_req & ~bus_ok;
    end
  end
  assign ACK_O = ack_reg;

  // Register writes; the controller is trusted to clear write strength for DLL-off.
  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= CTRL_RESET;
      mr0_reg  <= '0;
      mr1_reg  <= '0;
      mr2_reg  <= '0;
    end
    else if (CE_I && bus_req && bus_ok && WE_I)
    begin
      case (ADR_I)
        ADR_CTRL: ctrl_reg <= lane_merge(ctrl_reg, DAT_I, SEL_I);
        ADR_MR0:  mr0_reg  <= MODE_W'(lane_merge(32'(mr0_reg), DAT_I, SEL_I));
        ADR_MR1:  mr1_reg  <= MODE_W'(lane_merge(32'(mr1_reg), DAT_I, SEL_I));
        ADR_MR2:  mr2_reg  <= MODE_W'(lane_merge(32'(mr2_reg), DAT_I, SEL_I)); // R11
        default:  ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Read data is registered; status bits show live termination state.
  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dat_reg <= '0;
    end
    else if (CE_I && bus_req)
    begin
      case (ADR_I)
        ADR_CTRL: dat_reg <= {3'h0, viol_reg, 1'b0, async_mode, wr_sel_reg, term_en_reg,
                              ctrl_reg[23:0]};
        ADR_MR0:  dat_reg <= 32'(mr0_reg);
        ADR_MR1:  dat_reg <= 32'(mr1_reg);
        ADR_MR2:  dat_reg <= 32'(mr2_reg);
        default:  dat_reg <= '0;
      endcase
    end
  end
  assign DAT_O = dat_reg;

  // Write strength only shows while termination itself is on.
  assign TERM_EN_O        = term_en_reg;
  assign TERM_WRITE_SEL_O = wr_sel_reg & term_en_reg; // R9
  assign ASYNC_MODE_O     = async_mode;

endmodule : dtc_term_ctrl

// ===== verif/dtc_term_ctrl_sva.sv
`timescale 1ns/100ps
// Watches the termination controller from its top-level pins only.
module dtc_term_ctrl_chk
  import dtc_pkg::*;
(
  input wire logic             CLK_I,
  input wire logic             RESET_N_I,
  input wire logic             CE_I,
  input wire logic             TERM_PIN_I,
  input wire logic             WRITE_CMD_I,
  input wire logic             CYC_I,
  input wire logic             STB_I,
  input wire logic             WE_I,
  input wire logic [3:0]       ADR_I,
  input wire logic             ACK_O,
  input wire logic             ERR_O,
  input wire logic             TERM_EN_O,
  input wire logic             TERM_WRITE_SEL_O,
  input wire logic [NOM_W-1:0] NOM_STRENGTH_O,
  input wire logic [WRS_W-1:0] WR_STRENGTH_O
);
  logic [6:0] low_cnt;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // Counts cycles of a low pin; 70 is beyond the longest possible off latency.
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      low_cnt <= 7'h00;
    else if (TERM_PIN_I)
      low_cnt <= 7'h00;
    else if (low_cnt != 7'h64)
      low_cnt <= low_cnt + 7'h01;
  end
  a_bus_answer: assert property ((CYC_I && STB_I && CE_I && !ACK_O && !ERR_O) |=> (ACK_O || ERR_O))
    else $error("bus request not answered in the next cycle");
  a_ack_pulse: assert property (ACK_O |=> !ACK_O) else $error("ack longer than one cycle");
  a_err_pulse: assert property (ERR_O |=> !ERR_O) else $error("err longer than one cycle");
  a_err_unmapped: assert property (ERR_O |-> ADR_I[1:0] != 2'h0) else $error("err on mapped address");
  a_ack_mapped: assert property (ACK_O |-> ADR_I[1:0] == 2'h0) else $error("ack on unmapped address");
  a_sel_gated: assert property (TERM_WRITE_SEL_O |-> TERM_EN_O)
    else $error("write strength selected while termination off");
  a_nom_source: assert property ($changed(NOM_STRENGTH_O) |->
    (ACK_O && WE_I && ADR_I == ADR_MR1) || $past(ACK_O && WE_I && ADR_I == ADR_MR1))
    else $error("nominal strength changed without a register write");
  a_wrs_source: assert property ($changed(WR_STRENGTH_O) |->
    (ACK_O && WE_I && ADR_I == ADR_MR2) || $past(ACK_O && WE_I && ADR_I == ADR_MR2))
    else $error("write strength changed without a register write");
  a_no_dyn_write: assert property ((WRITE_CMD_I && WR_STRENGTH_O == 2'h0 && !TERM_WRITE_SEL_O)
    |=> !TERM_WRITE_SEL_O [*8]) else $error("strength switched with dynamic mode off");
  a_off_bound: assert property (low_cnt >= 7'h46 |-> !TERM_EN_O)
    else $error("termination still on long after pin low");
endmodule : dtc_term_ctrl_chk

bind dtc_term_ctrl dtc_term_ctrl_chk u_chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .CE_I(CE_I),
  .TERM_PIN_I(TERM_PIN_I), .WRITE_CMD_I(WRITE_CMD_I), .CYC_I(CYC_I), .STB_I(STB_I),
  .WE_I(WE_I), .ADR_I(ADR_I), .ACK_O(ACK_O), .ERR_O(ERR_O), .TERM_EN_O(TERM_EN_O),
  .TERM_WRITE_SEL_O(TERM_WRITE_SEL_O), .NOM_STRENGTH_O(NOM_STRENGTH_O),
  .WR_STRENGTH_O(WR_STRENGTH_O));

// ===== verif/dtc_mc_model.sv
`timescale 1ns/100ps
// Memory controller stand-in: drives the termination pin and write commands.
module dtc_mc_model
  import dtc_pkg::*;
(
  input  wire logic clk_i,
  output logic      pin_o,
  output logic      wr_o,
  output logic      chop_o
);
  int cyc_cnt;
  int low_ok;
  initial
  begin
    pin_o = 1'h0;
    wr_o = 1'h0;
    chop_o = 1'h0;
    cyc_cnt = 0;
    low_ok = 0;
  end
  // One-cycle write strobe; the chop line is inverted once it is no longer valid.
  always @(posedge clk_i)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (wr_o)
    begin
      wr_o <= 1'h0;
      chop_o <= ~chop_o;
    end
  end
  task automatic pin_up();
    @(posedge clk_i);
    pin_o <= 1'h1;
    low_ok = cyc_cnt + MIN_PIN_HIGH_SHORT + 1;
  endtask : pin_up
  // Writes are never issued in power-down by the caller.
  task automatic wr_cmd(input logic chop);
    int need;
    @(posedge clk_i);
    wr_o <= 1'h1;
    chop_o <= chop;
    need = cyc_cnt + (chop ? MIN_PIN_HIGH_SHORT : MIN_PIN_HIGH_LONG) + 1;
    if (pin_o && low_ok < need)
      low_ok = need;
  endtask : wr_cmd
  // Lowering waits out both minimum high times, however late it is asked for.
  task automatic pin_down();
    while (cyc_cnt < low_ok)
      @(posedge clk_i);
    @(posedge clk_i);
    pin_o <= 1'h0;
  endtask : pin_down
endmodule : dtc_mc_model

// ===== verif/dtc_term_ctrl_tb_top.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("mismatch at %0t: got %0h want %0h", $time, got, exp); end end
module dtc_term_ctrl_tb_top
  import dtc_pkg::*;
;
  logic        clk, rst_n, cyc, stb, we, ack, err, ten, tsel, asy, pin, wcmd, chop, e;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [2:0]  nom;
  logic [1:0]  wrs;
  int          error_cnt, num_checks;
  dtc_mc_model ctl (.clk_i(clk), .pin_o(pin), .wr_o(wcmd), .chop_o(chop));
  dtc_term_ctrl uut (.CLK_I(clk), .RESET_N_I(rst_n), .CE_I(1'h1), .TERM_PIN_I(pin),
    .WRITE_CMD_I(wcmd), .WRITE_CHOP_I(chop), .PIN_HIGH_VIOL_CLR_I(1'h0), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(wdat), .DAT_O(rdat),
    .ACK_O(ack), .ERR_O(err), .TERM_EN_O(ten), .TERM_WRITE_SEL_O(tsel),
    .NOM_STRENGTH_O(nom), .WR_STRENGTH_O(wrs), .ASYNC_MODE_O(asy));
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  // Classic single cycle; the request is held until ack or err is seen at an edge.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    n = 0;
    @(posedge clk);
    while (ack !== 1'h1 && err !== 1'h1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    q = rdat;
    e = err;
    {cyc, stb} <= 2'h0;
    #1;
    if (n == 20)
    begin
      `CHK(n, 0)
      conclude();
    end
  endtask : wb
  // Counts edges until termination (s=0) or write select (s=1) reaches v.
  task automatic lat(input logic s, input logic v, input int exp);
    int n;
    n = 0;
    while (n < 100 && (s ? tsel : ten) !== v)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(n, exp)
  endtask : lat
  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    {rst_n, cyc, stb, we, adr, wdat, error_cnt, num_checks} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    wb(0, ADR_CTRL, 0);
    `CHK(q, CTRL_RESET)
    wb(1, 4'h2, 32'hFFFF_FFFF);
    `CHK(e, 1'h1)
    // Every nominal code; the upper half of a mode register reads zero.
    for (int i = 0; i < 8; i++)
    begin
      wb(1, ADR_MR1, 32'hABCD_0000 | (i[2] << 9) | (i[1] << 6) | (i[0] << 2));
      `CHK(nom, i[2:0])
      wb(0, ADR_MR1, 0);
      `CHK(q, 32'h0000_0000 | (i[2] << 9) | (i[1] << 6) | (i[0] << 2))
    end
    for (int j = 0; j < 4; j++)
    begin
      wb(1, ADR_MR2, j << 9);
      `CHK(wrs, j[1:0])
    end
    // Pin latency with and without additive latency, write latency 5.
    for (int al = 0; al < 4; al += 2)
    begin
      wb(1, ADR_CTRL, 32'h0004_0005 | (al << 8));
      ctl.pin_up();
      lat(0, 1, al + 6);
      ctl.pin_down();
      lat(0, 0, al + 6);
    end
    // Dynamic switch for chop then full bursts, termination held on meanwhile.
    wb(1, ADR_CTRL, 32'h0004_0005);
    ctl.pin_up();
    lat(0, 1, 6);
    for (int c = 1; c >= 0; c--)
    begin
      ctl.wr_cmd(c[0]);
      lat(1, 1, 4);
      lat(1, 0, c ? 4 : 6);
      `CHK(ten, 1'h1)
    end
    // Dynamic mode cleared: a write leaves the nominal strength alone.
    wb(1, ADR_MR2, 0);
    ctl.wr_cmd(0);
    repeat (12)
    begin
      @(posedge clk);
      #1;
      `CHK(tsel, 1'h0)
    end
    wb(1, ADR_CTRL, 32'h0005_0005);
    repeat (8) @(posedge clk);
    #1;
    `CHK(ten, 1'h0)
    ctl.pin_down();
    // Frozen power-down: additive latency ignored, fixed short delays.
    wb(1, ADR_CTRL, 32'h0006_0405);
    wb(1, ADR_MR0, 0);
    `CHK(asy, 1'h1)
    ctl.pin_up();
    lat(0, 1, 5);
    ctl.pin_down();
    lat(0, 0, 5);
    wb(1, ADR_MR0, 32'h0000_1000);
    `CHK(asy, 1'h0)
    // Every pin-high minimum was kept, so the sticky violation flag stays clear.
    wb(0, ADR_CTRL, 0);
    `CHK(q[28], 1'h0)
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end
endmodule : dtc_term_ctrl_tb_top
